// ### inc/prt_pkg.sv
/*
  Constants shared by the periodic timer: register offsets, field positions,
  reset values and mode encodings.
  Assumes a 3-bit word address and 16-bit register data on the software port.
*/
package prt_pkg;
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 16;
  localparam int          CNT_W         = 10;

  // Register offsets (word addresses).
  localparam logic [2:0]  OFS_CTRL1     = 3'h0;
  localparam logic [2:0]  OFS_CTRL0     = 3'h1;
  localparam logic [2:0]  OFS_CMPA      = 3'h2;
  localparam logic [2:0]  OFS_CMPP      = 3'h3;
  localparam logic [2:0]  OFS_COUNT     = 3'h4;
  localparam logic [2:0]  OFS_FLAGS     = 3'h5;

  // Field positions in timer_control_one.
  localparam int          BIT_MODE_HI   = 7;
  localparam int          BIT_MODE_LO   = 6;
  localparam int          BIT_PA_HI     = 5;
  localparam int          BIT_PA_LO     = 4;
  localparam int          BIT_OUT_LVL   = 3;
  localparam int          BIT_OUT_INV   = 2;
  localparam int          BIT_CLR_SRC   = 0;
  // Field positions in timer_control_zero.
  localparam int          BIT_RUN       = 3;
  localparam int          BIT_CAP_SRC   = 1;
  // Field positions in the flag register.
  localparam int          BIT_FLAG_P    = 1;
  localparam int          BIT_FLAG_A    = 0;

  // Reset values.
  localparam logic [15:0] RST_CTRL1     = 16'h0000;
  localparam logic [15:0] RST_CTRL0     = 16'h0000;
  localparam logic [9:0]  RST_CMP       = 10'h000;

  // Mode select encodings.
  localparam logic [1:0]  MODE_CMP      = 2'h0;
  localparam logic [1:0]  MODE_CAP      = 2'h1;
  localparam logic [1:0]  MODE_PWM      = 2'h2;
  localparam logic [1:0]  MODE_TMR      = 2'h3;

  // Pin action encodings.
  localparam logic [1:0]  PA_FORCE_LO   = 2'h0;
  localparam logic [1:0]  PA_FORCE_HI   = 2'h1;
  localparam logic [1:0]  PA_PWM        = 2'h2;
  localparam logic [1:0]  PA_SINGLE     = 2'h3;
  // Capture edge encodings share the pin action field.
  localparam logic [1:0]  PA_CAP_RISE   = 2'h0;
  localparam logic [1:0]  PA_CAP_FALL   = 2'h1;
  localparam logic [1:0]  PA_CAP_BOTH   = 2'h2;
endpackage

// ### inc/prt_cnt_if.sv
/*
  Carrier between the timer control logic and the counter core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface prt_cnt_if;
  logic       run;       // Counter enabled.
  logic       run_rise;  // Run bit has just risen.
  logic       clr_p_en;  // Comparator P match clears the counter.
  logic       clr_a_en;  // Comparator A match clears the counter.
  logic [9:0] cmp_a;     // Comparator A value.
  logic [9:0] cmp_p;     // Comparator P value.
  logic [9:0] count;     // Counter value.
  logic       match_a;   // Comparator A match pulse.
  logic       match_p;   // Comparator P match pulse.

  modport core (input run, run_rise, clr_p_en, clr_a_en, cmp_a, cmp_p, output count, match_a, match_p);
  modport ctl  (output run, run_rise, clr_p_en, clr_a_en, cmp_a, cmp_p, input count, match_a, match_p);
endinterface

// ### logic/prt_edge.sv
/*
  Rising and falling edge detector for a pin.
  Assumes the pin is already synchronous to the clock.
*/
`timescale 1ns/1ps
module prt_edge (
  input  wire logic clock,   // System clock.
  input  wire logic rst_n,   // Asynchronous reset, active low.
  input  wire logic pin,     // Sampled pin level.
  output wire logic rise,    // Low to high this cycle.
  output wire logic fall     // High to low this cycle.
);
  logic prev_r;

  // Previous level of the pin.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end

  // Edges compare the present level with the previous one.
  assign rise = pin & ~prev_r;
  assign fall = ~pin & prev_r;
endmodule

// ### logic/prt_core.sv
/*
  Ten-bit counter with comparators A and P.
  Assumes the control side raises run_rise for one cycle when counting starts.
*/
`timescale 1ns/1ps
module prt_core (
  input  wire logic clock,   // System clock.
  input  wire logic rst_n,   // Asynchronous reset, active low.
  prt_cnt_if.core   cif      // Counter control and results.
);
  import prt_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [CNT_W-1:0] p_last;
  logic             live;
  logic             clear;

  // A P value of zero wraps to the full count, so the period is P counts.
  assign p_last      = cif.cmp_p - 10'h001;
  assign live        = cif.run & ~cif.run_rise;
  assign cif.match_a = live & (count_r == cif.cmp_a);
  assign cif.match_p = live & (count_r == p_last);
  assign clear       = (cif.match_p & cif.clr_p_en) | (cif.match_a & cif.clr_a_en);
  assign cif.count   = count_r;

  // Restart on run rise, hold while run is low, clear on the selected match, else advance by one.
  assign count_nxt = cif.run_rise ? 10'h000 :
                     !cif.run     ? count_r :
                     clear        ? 10'h000 : count_r + 10'h001;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 10'h000;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule

// ### logic/prt_top.sv
/*
  Periodic timer with PWM output, single pulse output and capture input modes,
  reached by a plain register port.
  Assumes pins are synchronous to the clock and the bus strobes are one cycle.

*/
`timescale 1ns/1ps
module prt_top (
  input  wire logic                  clock,            // System clock, 40 MHz.
  input  wire logic                  rst_n,            // Asynchronous reset, active low.
  input  wire logic [prt_pkg::ADDR_W-1:0] reg_addr,    // Register word address.
  input  wire logic [prt_pkg::DATA_W-1:0] reg_wdata,   // Register write data.
  input  wire logic                  reg_wr,           // Write strobe.
  input  wire logic                  reg_rd,           // Read strobe.
  output wire logic [prt_pkg::DATA_W-1:0] reg_rdata,   // Read data, cycle after the strobe.
  input  wire logic                  timer_io_pin_i,   // I/O pin level in.
  output wire logic                  timer_io_pin_o,   // I/O pin level out.
  output wire logic                  timer_io_pin_oe,  // I/O pin driven when high.
  input  wire logic                  timer_clock_pin,  // Timer clock pin level.
  output wire logic                  match_a_flag,     // Sticky comparator A or capture flag.
  output wire logic                  match_p_flag      // Sticky comparator P flag.
);
  import prt_pkg::*;

  // Register select: a strobe qualified by one word address.
  function automatic logic reg_hit(input logic              strobe,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    reg_hit = strobe & (addr == ofs);
  endfunction

  // Zero-extends a counter-width value to a register word; upper bits read zero.
  function automatic logic [DATA_W-1:0] to_word(input logic [CNT_W-1:0] v);
    to_word = {6'h00, v};
  endfunction

  // Control, flag, pin and read data registers.
  logic [1:0]        mode_select_r;
  logic [1:0]        pin_action_r;
  logic              output_level_ctl_r;
  logic              output_invert_r;
  logic              clear_source_sel_r;
  logic              run_bit_r;
  logic              run_prev_r;
  logic              capture_source_sel_r;
  logic [CNT_W-1:0]  compare_a_value_r;
  logic [CNT_W-1:0]  compare_p_value_r;
  logic              flag_a_r;
  logic              flag_p_r;
  logic              pin_o_r;
  logic              pin_oe_r;
  logic [DATA_W-1:0] rdata_r;

  // Next values.
  logic              run_bit_nxt;
  logic [CNT_W-1:0]  compare_a_value_nxt;
  logic              flag_a_nxt;
  logic              flag_p_nxt;
  logic              pin_o_nxt;
  logic              pin_oe_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  // Decode and status wires.
  logic              wr_ctrl1;
  logic              wr_ctrl0;
  logic              wr_cmpa;
  logic              wr_cmpp;
  logic              wr_flags;
  logic              mode_cap;
  logic              mode_pwm;
  logic              mode_single;
  logic              mode_cmp;
  logic              io_rise;
  logic              io_fall;
  logic              ck_rise;
  logic              ck_fall;
  logic              cap_rise;
  logic              cap_fall;
  logic              cap_hit;
  logic              single_trig;
  logic              single_end;
  logic              set_a;
  logic              set_p;
  logic              wave_active;
  logic              wave_level;
  logic              pin_raw;
  logic [DATA_W-1:0] ctrl1_view;
  logic [DATA_W-1:0] ctrl0_view;
  logic [DATA_W-1:0] rd_mux;

  prt_cnt_if cif ();

  // Counter core and pin edge detectors.
  prt_core u_core (
    .clock (clock),
    .rst_n (rst_n),
    .cif   (cif.core)
  );

  prt_edge u_io_edge (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (timer_io_pin_i),
    .rise  (io_rise),
    .fall  (io_fall)
  );

  prt_edge u_ck_edge (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (timer_clock_pin),
    .rise  (ck_rise),
    .fall  (ck_fall)
  );

  // Write strobe decode.
  assign wr_ctrl1 = reg_hit(reg_wr, reg_addr, OFS_CTRL1);
  assign wr_ctrl0 = reg_hit(reg_wr, reg_addr, OFS_CTRL0);
  assign wr_cmpa  = reg_hit(reg_wr, reg_addr, OFS_CMPA);
  assign wr_cmpp  = reg_hit(reg_wr, reg_addr, OFS_CMPP);
  assign wr_flags = reg_hit(reg_wr, reg_addr, OFS_FLAGS);

  // Mode decode; software picks the mode and pin action pair.
  assign mode_cap    = (mode_select_r == MODE_CAP);
  assign mode_pwm    = (mode_select_r == MODE_PWM) & (pin_action_r != PA_SINGLE);
  assign mode_single = (mode_select_r == MODE_PWM) & (pin_action_r == PA_SINGLE);
  assign mode_cmp    = (mode_select_r == MODE_CMP) | (mode_select_r == MODE_TMR);

  // Counter steering; single pulse mode never clears on a match.
  assign cif.run      = run_bit_r;
  assign cif.run_rise = run_bit_r & ~run_prev_r;
  assign cif.clr_p_en = mode_pwm | mode_cap | (mode_cmp & ~clear_source_sel_r);
  assign cif.clr_a_en = mode_cmp & clear_source_sel_r;
  assign cif.cmp_a    = compare_a_value_r;
  assign cif.cmp_p    = compare_p_value_r;

  // Capture source and active edge selection.
  assign cap_rise = capture_source_sel_r ? ck_rise : io_rise;
  assign cap_fall = capture_source_sel_r ? ck_fall : io_fall;
  assign cap_hit  = mode_cap & run_bit_r &
                    (((pin_action_r == PA_CAP_RISE) & cap_rise) |
                     ((pin_action_r == PA_CAP_FALL) & cap_fall) |
                     ((pin_action_r == PA_CAP_BOTH) & (cap_rise | cap_fall)));

  // Single pulse start by clock pin edge, end by comparator A.
  assign single_trig = mode_single & ck_rise;
  assign single_end  = mode_single & cif.match_a;

  // Run bit: software write, then hardware clear, then hardware set wins.
  assign run_bit_nxt = single_trig ? 1'b1 :
                       single_end  ? 1'b0 :
                       wr_ctrl0    ? reg_wdata[BIT_RUN] : run_bit_r;

  // Capture overrides a software write to the A compare value.
  assign compare_a_value_nxt = cap_hit ? cif.count :
                               wr_cmpa ? reg_wdata[CNT_W-1:0] : compare_a_value_r;

  // Flag sources; P matches raise nothing in single pulse mode.
  assign set_a = (cif.match_a & ~mode_cap) | cap_hit;
  assign set_p = cif.match_p & ~mode_single & ~(mode_cmp & clear_source_sel_r);

  // Write one clears a flag; a new event in the same cycle keeps it set.
  assign flag_a_nxt = (flag_a_r & ~(wr_flags & reg_wdata[BIT_FLAG_A])) | set_a;
  assign flag_p_nxt = (flag_p_r & ~(wr_flags & reg_wdata[BIT_FLAG_P])) | set_p;

  // Waveform: PWM active while count is below A, which covers A at or above the period.
  assign wave_active = run_bit_r & (mode_single ? 1'b1 : (cif.count < compare_a_value_r));
  assign wave_level  = wave_active ? output_level_ctl_r : ~output_level_ctl_r;

  // Forced levels only mask the pin; counting is untouched.
  assign pin_raw = (mode_pwm & (pin_action_r == PA_FORCE_LO)) ? 1'b0 :
                   (mode_pwm & (pin_action_r == PA_FORCE_HI)) ? 1'b1 : wave_level;
  assign pin_o_nxt  = (pin_raw ^ output_invert_r) & pin_oe_nxt;
  assign pin_oe_nxt = mode_pwm | mode_single;

  // Register read views.
  assign ctrl1_view = {8'h00, mode_select_r, pin_action_r, output_level_ctl_r,
                       output_invert_r, 1'b0, clear_source_sel_r};
  assign ctrl0_view = {12'h000, run_bit_r, 1'b0, capture_source_sel_r, 1'b0};

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    unique case (reg_addr)
      OFS_CTRL1: rd_mux = ctrl1_view;
      OFS_CTRL0: rd_mux = ctrl0_view;
      OFS_CMPA:  rd_mux = to_word(compare_a_value_r);
      OFS_CMPP:  rd_mux = to_word(compare_p_value_r);
      OFS_COUNT: rd_mux = to_word(cif.count);
      OFS_FLAGS: rd_mux = {14'h0000, flag_p_r, flag_a_r};
      default:   rd_mux = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  assign rdata_nxt = reg_rd ? rd_mux : 16'h0000;

  // Control register stores.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_select_r        <= RST_CTRL1[BIT_MODE_HI:BIT_MODE_LO];
      pin_action_r         <= RST_CTRL1[BIT_PA_HI:BIT_PA_LO];
      output_level_ctl_r   <= RST_CTRL1[BIT_OUT_LVL];
      output_invert_r      <= RST_CTRL1[BIT_OUT_INV];
      clear_source_sel_r   <= RST_CTRL1[BIT_CLR_SRC];
      capture_source_sel_r <= RST_CTRL0[BIT_CAP_SRC];
    end else if (wr_ctrl1) begin
      mode_select_r        <= reg_wdata[BIT_MODE_HI:BIT_MODE_LO];
      pin_action_r         <= reg_wdata[BIT_PA_HI:BIT_PA_LO];
      output_level_ctl_r   <= reg_wdata[BIT_OUT_LVL];
      output_invert_r      <= reg_wdata[BIT_OUT_INV];
      clear_source_sel_r   <= reg_wdata[BIT_CLR_SRC];
    end else if (wr_ctrl0) begin
      capture_source_sel_r <= reg_wdata[BIT_CAP_SRC];
    end
  end

  // Comparator A value; both capture and software load it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value_r <= RST_CMP;
    end else begin
      compare_a_value_r <= compare_a_value_nxt;
    end
  end

  // Comparator P value; only software loads it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compare_p_value_r <= RST_CMP;
    end else begin
      compare_p_value_r <= wr_cmpp ? reg_wdata[CNT_W-1:0] : compare_p_value_r;
    end
  end

  // Run bit and its previous value; together they mark a run rise.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_bit_r  <= RST_CTRL0[BIT_RUN];
      run_prev_r <= RST_CTRL0[BIT_RUN];
    end else begin
      run_bit_r  <= run_bit_nxt;
      run_prev_r <= run_bit_r;
    end
  end

  // Sticky event flags.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= flag_a_nxt;
      flag_p_r <= flag_p_nxt;
    end
  end

  // Pin level and enable are registered so a mode change cannot glitch the pin.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_r  <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_o_r  <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  // Read data register; it returns to zero after one cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata       = rdata_r;
  assign timer_io_pin_o  = pin_o_r;
  assign timer_io_pin_oe = pin_oe_r;
  assign match_a_flag    = flag_a_r;
  assign match_p_flag    = flag_p_r;
endmodule

// ### verif/prt_checker.sv
/*
  Port-level assertions for the periodic timer top module.
  Assumes it is bound to prt_top and that software follows the register port strobe rules.
*/
`timescale 1ns/1ps
module prt_checker (
  input wire logic                       clock,           // System clock.
  input wire logic                       rst_n,           // Asynchronous reset, active low.
  input wire logic [prt_pkg::ADDR_W-1:0] reg_addr,        // Register word address.
  input wire logic [prt_pkg::DATA_W-1:0] reg_wdata,       // Register write data.
  input wire logic                       reg_wr,          // Write strobe.
  input wire logic                       reg_rd,          // Read strobe.
  input wire logic [prt_pkg::DATA_W-1:0] reg_rdata,       // Read data.
  input wire logic                       timer_io_pin_i,  // I/O pin level in.
  input wire logic                       timer_io_pin_o,  // I/O pin level out.
  input wire logic                       timer_io_pin_oe, // I/O pin drive enable.
  input wire logic                       timer_clock_pin, // Timer clock pin level.
  input wire logic                       match_a_flag,    // Comparator A or capture flag.
  input wire logic                       match_p_flag     // Comparator P flag.
);
  import prt_pkg::*;

  logic [7:0] ctl1_r;   // Mirror of timer_control_one.
  logic [7:0] ctl1_nxt; // Next value of the mirror.
  wire  [1:0] mode;     // Mode select field.
  wire  [1:0] pact;     // Pin action field.
  wire        single;   // Single pulse mode selected.
  wire        clr_a;    // Software clears flag A this cycle.
  wire        clr_p;    // Software clears flag P this cycle.

  // Decode the mirrored control fields and the flag clear writes.
  assign ctl1_nxt = (reg_wr && reg_addr == OFS_CTRL1) ? (reg_wdata[7:0] & 8'hFD) : ctl1_r;
  assign mode     = ctl1_r[7:6];
  assign pact     = ctl1_r[5:4];
  assign single   = (mode == MODE_PWM) && (pact == PA_SINGLE);
  assign clr_a    = reg_wr && (reg_addr == OFS_FLAGS) && reg_wdata[BIT_FLAG_A];
  assign clr_p    = reg_wr && (reg_addr == OFS_FLAGS) && reg_wdata[BIT_FLAG_P];

  // Track software writes so that mode-dependent checks know the current setup.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_r <= 8'h00;
    end else begin
      ctl1_r <= ctl1_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_ctl_read;
    reg_rd && (reg_addr == OFS_CTRL1);
  endsequence
  sequence s_pin_trig;
    single && $stable(ctl1_r) && ctl1_r[3:2] == 2'h2 && $rose(timer_clock_pin) && !timer_io_pin_o;
  endsequence
  sequence s_pulse_on;
    timer_io_pin_o [*2];
  endsequence

  property p_ctl_readback;
    s_ctl_read |=> (reg_rdata == {8'h00, $past(ctl1_r)});
  endproperty
  property p_a_sticky;
    match_a_flag && !clr_a |=> match_a_flag;
  endproperty
  property p_p_sticky;
    match_p_flag && !clr_p |=> match_p_flag;
  endproperty
  property p_cap_quiet;
    (mode == MODE_CAP) && ($past(ctl1_r[7:6]) == MODE_CAP) |-> !timer_io_pin_oe && !timer_io_pin_o;
  endproperty
  property p_pwm_drive;
    (mode == MODE_PWM) && ($past(ctl1_r[7:6]) == MODE_PWM) |-> timer_io_pin_oe;
  endproperty
  property p_force;
    (mode == MODE_PWM) && !pact[1] && $stable(ctl1_r) |-> timer_io_pin_o == (pact[0] ^ ctl1_r[BIT_OUT_INV]);
  endproperty
  property p_sp_no_p;
    single && $stable(ctl1_r) |-> !$rose(match_p_flag);
  endproperty
  property p_sp_end;
    single && $stable(ctl1_r) && ctl1_r[3:2] == 2'h2 && $rose(match_a_flag) |=> !timer_io_pin_o;
  endproperty
  property p_sp_start;
    s_pin_trig |-> ##2 s_pulse_on;
  endproperty

  a_ctl_readback: assert property (p_ctl_readback) else $error("control readback differs");
  a_a_sticky: assert property (p_a_sticky) else $error("flag A dropped without clear");
  a_p_sticky: assert property (p_p_sticky) else $error("flag P dropped without clear");
  a_cap_quiet: assert property (p_cap_quiet) else $error("pin driven in capture mode");
  a_pwm_drive: assert property (p_pwm_drive) else $error("pin not driven in PWM mode");
  a_force: assert property (p_force) else $error("forced pin level wrong");
  a_sp_no_p: assert property (p_sp_no_p) else $error("P flag set in single pulse");
  a_sp_end: assert property (p_sp_end) else $error("pulse did not end on A match");
  a_sp_start: assert property (p_sp_start) else $error("pulse did not start on trigger");
endmodule

bind prt_top prt_checker chk (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_io_pin_i(timer_io_pin_i), .timer_io_pin_o(timer_io_pin_o),
  .timer_io_pin_oe(timer_io_pin_oe), .timer_clock_pin(timer_clock_pin), .match_a_flag(match_a_flag),
  .match_p_flag(match_p_flag)
);

// ### verif/prt_pin_src.sv
/*
  External pulse source for the timer pins: a fire request makes a pulse of HOLD cycles.
  Assumes requests are one clock long and spaced wider than a pulse.
*/
`timescale 1ns/1ps
module prt_pin_src #(
  parameter int HOLD = 3           // Pulse length in clock cycles.
) (
  input  wire logic clock,         // System clock.
  input  wire logic rst_n,         // Asynchronous reset, active low.
  input  wire logic fire_io,       // Start a pulse on the I/O pin.
  input  wire logic fire_ck,       // Start a pulse on the clock pin.
  output wire logic io_pin,        // I/O pin drive level.
  output wire logic ck_pin         // Clock pin drive level.
);
  logic [3:0] io_left_r;           // Cycles left high on the I/O pin.
  logic [3:0] ck_left_r;           // Cycles left high on the clock pin.

  // A pin stays high while its counter runs, giving one rising and one falling edge per request.
  assign io_pin = (io_left_r != 4'h0);
  assign ck_pin = (ck_left_r != 4'h0);

  // Load on request, otherwise count down to idle low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_left_r <= 4'h0;
      ck_left_r <= 4'h0;
    end else begin
      io_left_r <= fire_io ? 4'(HOLD) : (io_pin ? io_left_r - 4'h1 : 4'h0);
      ck_left_r <= fire_ck ? 4'(HOLD) : (ck_pin ? ck_left_r - 4'h1 : 4'h0);
    end
  end
endmodule

// ### verif/tb_top.sv
/*
  Self-checking bench for the periodic timer: PWM, forced pin, single pulse and capture.
  Assumes the checker is bound to prt_top and the pin source model drives both timer pins.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; $display("FAIL t=%0t value mismatch", $time); end end
module tb_top;
  import prt_pkg::*;
  localparam int     HOLD = 3;
  logic              clock, rst_n, reg_wr, reg_rd, fire_io, fire_ck;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, rdv;
  logic [9:0]        cnt, ex10;
  wire  [DATA_W-1:0] reg_rdata;
  wire               pin_o, pin_oe, src_io, src_ck, match_a, match_p, io_wire;
  int                err_total, n_compared, ones, peff, hi, ex;
  int                tp[7] = '{1023, 0, 5, 7, 4, 4, 4};
  int                ta[7] = '{1, 256, 5, 9, 1, 1, 1};
  int                tl[7] = '{1, 1, 1, 1, 1, 0, 1};
  int                ti[7] = '{0, 0, 0, 0, 0, 0, 1};

  // The timer owns the I/O wire while it drives it, the source otherwise.
  assign io_wire = pin_oe ? pin_o : src_io;

  prt_top uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_io_pin_i(io_wire), .timer_io_pin_o(pin_o),
    .timer_io_pin_oe(pin_oe), .timer_clock_pin(src_ck), .match_a_flag(match_a), .match_p_flag(match_p));
  prt_pin_src #(.HOLD(HOLD)) src (.clock(clock), .rst_n(rst_n), .fire_io(fire_io), .fire_ck(fire_ck),
    .io_pin(src_io), .ck_pin(src_ck));

  // Clock at 40 MHz.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read, optionally firing a pin pulse in the strobe cycle.
  task automatic rd(input logic [2:0] a, input logic fi, input logic fc, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    fire_io <= fi;
    fire_ck <= fc;
    @(posedge clock);
    reg_rd <= 1'b0;
    fire_io <= 1'b0;
    fire_ck <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Waits n cycles and counts cycles with the pin high.
  task automatic meas(input int n);
    ones = 0;
    repeat (n) begin
      @(posedge clock);
      #1 ones += (pin_o === 1'b1) ? 1 : ((pin_o === 1'b0) ? 0 : 4096);  // An unknown spoils the count.
    end
  endtask

  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    test_done();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, fire_io, fire_ck, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFS_CTRL1, 1'b0, 1'b0, rdv);
    `CHK(rdv, 16'h0000)
    wr(3'h6, 16'hFFFF);
    rd(3'h6, 1'b0, 1'b0, rdv);
    `CHK(rdv, 16'h0000)
    // PWM periods, duties, levels and inversion from the table.
    for (int i = 0; i < 7; i++) begin
      peff = (tp[i] == 0) ? 1024 : tp[i];
      hi = (ta[i] < peff) ? ta[i] : peff;
      ex = (tl[i] != ti[i]) ? 2 * hi : 2 * (peff - hi);
      wr(OFS_CTRL0, 16'h0000);
      wr(OFS_CMPP, 16'(tp[i]));
      wr(OFS_CMPA, 16'(ta[i]));
      wr(OFS_CTRL1, {8'h00, 4'hA, 1'(tl[i]), 1'(ti[i]), 2'h1});
      rd(OFS_CTRL1, 1'b0, 1'b0, rdv);
      wr(OFS_FLAGS, 16'h0003);
      wr(OFS_CTRL0, 16'h0008);
      meas(8);
      meas(2 * peff);
      `CHK(ones, ex)
      `CHK(match_p, 1'b1)
      `CHK(match_a, (ta[i] < peff))
    end
    // Forced levels while the counter keeps matching.
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL1, {8'h00, 2'h2, 1'b0, 1'(p), 4'h8});
      wr(OFS_FLAGS, 16'h0003);
      meas(12);
      `CHK(ones, 12 * p)
      `CHK(match_p, 1'b1)
    end
    // Single pulse from the clock pin, then from software.
    wr(OFS_CTRL0, 16'h0000);
    wr(OFS_CMPA, 16'h0005);
    wr(OFS_CMPP, 16'h0002);
    wr(OFS_CTRL1, 16'h00B9);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_FLAGS, 16'h0003);
      if (k == 0) rd(OFS_CTRL0, 1'b0, 1'b1, rdv);
      else wr(OFS_CTRL0, 16'h0008);
      meas(30);
      `CHK(ones, 7)
      `CHK(match_a, 1'b1)
      `CHK(match_p, 1'b0)
      rd(OFS_CTRL0, 1'b0, 1'b0, rdv);
      `CHK(rdv[BIT_RUN], 1'b0)
    end
    // Capture on each source and edge choice.
    wr(OFS_CTRL0, 16'h0000);
    wr(OFS_CMPP, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 4; e++) begin
        wr(OFS_CTRL1, {8'h00, 2'h1, 2'(e), 4'hD});
        wr(OFS_CTRL0, {12'h000, 2'h2, 1'(s), 1'b0});
        wr(OFS_CMPA, 16'h0000);
        wr(OFS_FLAGS, 16'h0003);
        rd(OFS_COUNT, 1'(s), 1'(!s), rdv);
        meas(8);
        `CHK(match_a, 1'b0)
        rd(OFS_COUNT, 1'(!s), 1'(s), rdv);
        cnt = rdv[9:0];
        meas(8);
        rd(OFS_CMPA, 1'b0, 1'b0, rdv);
        ex10 = (e == 3) ? 10'h000 : cnt + ((e == 0) ? 10'h001 : 10'(HOLD + 1));
        `CHK(rdv[9:0], ex10)
        `CHK(match_a, (e != 3))
      end
    end
    // Comparator P limits the free-running capture counter.
    wr(OFS_CTRL0, 16'h0000);
    wr(OFS_CMPP, 16'h0014);
    wr(OFS_CTRL0, 16'h0008);
    wr(OFS_FLAGS, 16'h0003);
    meas(30);
    `CHK(match_p, 1'b1)
    rd(OFS_COUNT, 1'b0, 1'b0, rdv);
    `CHK((rdv[9:0] < 10'h014), 1'b1)
    test_done();
  end
endmodule
